// ===== rtl/mute_mode_ctrl.sv
// Anti-plop mute sequencing, audio format and static mode pin control
//
// Functional notes
// - Channel 1 source change raises source 1 mute only, released after.
// - Channel 2 source change raises source 2 mute only, released after.
// - Mode, control or SPDIF input change on PLL DAC: master mute till lock.
// - Mode or control change on crystal DAC: master mute, release when done.
// - Noise shaper order or DAC polarity change: master mute, no lock wait.
// - Crystal source change mutes master briefly; mixer changes never mute.
// - Master bit clock is 64 fs at 256 fs, 48 fs at 384 fs.
// - Static formats: four input formats, output only I2S or MSB.
// - Microcontroller mode: input and output formats chosen independently.
// - Power-on reset restores all microcontroller defaults, synchronous ones too.
// - Static control uses microcontroller defaults for settings without pins.
// - Bit clock and word select direction follows the application mode.
// - Lock output high while the active input's clock source is locked.
// - Reset pin high resets; static select pin low chooses microcontroller.
// - Static SPDIF pick pins route one of four receive pins.
// - Three-level rate pin: low 44.1 kHz, mid 32 kHz, high 48 kHz.
// - Eleven static application modes, fourteen in microcontroller mode.
// - DAC mute is external mute pin ORed with software mute bit.
// - Soft mute ramp of 32 steps, four samples each, 128 in all.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mute_ctrl_map.svh"

module mute_mode_ctrl
    import mute_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [8:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [8:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pins_t pins,
    input wire logic fs_tick,
    output logic [1:0] ch1_src_ff,
    output logic [1:0] ch2_src_ff,
    output logic ns_order_ff,
    output logic dac_pol_ff,
    output logic mixer_en_ff,
    output logic mixer_pos_ff,
    output logic xtal_src_ff,
    output logic [2:0] in_fmt_ff,
    output logic [2:0] out_fmt_ff,
    output logic [6:0] bck_ratio_ff,
    output logic bck_ws_master_ff,
    output logic lock_ff,
    output logic dac_mute_ff,
    output logic source1_mute_flag_ff,
    output logic source2_mute_flag_ff,
    output logic master_mute_flag_ff,
    output logic [4:0] src1_coef_ff,
    output logic [4:0] src2_coef_ff,
    output logic [4:0] master_coef_ff,
    output logic [3:0] app_mode_ff,
    output logic [1:0] spdif_route_ff,
    output logic spdif_data_ff,
    output logic [1:0] xtal_rate_ff
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [6:0] ramp_next(input logic [6:0] pos,
                                             input logic req,
                                             input logic tick);
        logic [6:0] r;
        r = pos;
        if (tick && req && pos != `RAMP_FULL) begin
            r = pos + 7'h01;
        end else if (tick && !req && pos != 7'h00) begin
            r = pos - 7'h01;
        end
        return r;
    endfunction

    function automatic logic [1:0] lvl(input logic [1:0] pin);
        return (pin == LVL_HIGH || pin == 2'h3) ? 2'h2 : pin;
    endfunction

    function automatic logic dac_on_pll(input logic [3:0] m);
        return !(m == 4'h3 || m == 4'h4 || m == 4'h5 || m == 4'h9);
    endfunction

    function automatic logic spdif_in(input logic [3:0] m);
        return m == 4'h0 || m == 4'h2 || m == 4'h7 || m == 4'h9 ||
               m == 4'ha;
    endfunction

    function automatic logic i2s_lock(input logic [3:0] m);
        return m == 4'h1 || m == 4'h6 || m == 4'h8;
    endfunction

    // ****************************************
    // Pin synchronisers and reset
    // ****************************************
    pins_t meta_ff;
    pins_t pin_ff;
    logic soft_rst_ff;
    logic rst;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            pin_ff <= '0;
        end else begin
            meta_ff <= pins;
            pin_ff <= meta_ff;
        end
    end

    assign rst = !aresetn || pin_ff.reset_req || soft_rst_ff;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wd_ff;
    logic [8:0] wa_ff;
    logic do_wr;
    logic wr_ok;

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_ok = wa_ff == `OFS_SRC || wa_ff == `OFS_AUDIO ||
                   wa_ff == `OFS_IFACE || wa_ff == `OFS_SOFT_RESET;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            wa_ff <= 9'h000;
            wd_ff <= 32'h0000_0000;
        end else begin
            if (awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                wa_ff <= awaddr;
            end
            if (wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wd_ff <= wdata;
            end
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? 2'h0 : 2'h3;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Soft reset lands one cycle after the write so the response still goes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= do_wr && wa_ff == `OFS_SOFT_RESET;
        end
    end

    // ****************************************
    // Settings registers
    // ****************************************
    logic [3:0] pend_src_ff;
    logic [5:0] audio_ff;
    logic [2:0] reg_in_ff, reg_out_ff;
    logic reg_clk384_ff;
    logic [3:0] reg_mode_ff;
    logic [1:0] reg_pick_ff;
    logic [3:0] wd_mode;
    logic [2:0] wd_in, wd_out;

    assign wd_mode = wd_ff[`IF_MODE_LSB +: 4];
    assign wd_in = wd_ff[`IF_IN_LSB +: 3];
    assign wd_out = wd_ff[`IF_OUT_LSB +: 3];

    always_ff @(posedge aclk) begin
        if (rst) begin
            pend_src_ff <= `RST_SRC;
            audio_ff <= `RST_AUDIO;
            reg_in_ff <= `RST_FMT;
            reg_out_ff <= `RST_FMT;
            reg_clk384_ff <= 1'b0;
            reg_mode_ff <= `RST_MODE;
            reg_pick_ff <= `RST_PICK;
        end else if (do_wr) begin
            if (wa_ff == `OFS_SRC && wstrb[0]) begin
                pend_src_ff <= wd_ff[3:0];
            end
            if (wa_ff == `OFS_AUDIO && wstrb[0]) begin
                audio_ff <= wd_ff[5:0];
            end
            if (wa_ff == `OFS_IFACE) begin
                // Codes above MSB are ignored, the field keeps its value
                if (wstrb[0] && wd_in <= FMT_MSB) begin
                    reg_in_ff <= wd_in;
                end
                if (wstrb[0] && wd_out <= FMT_MSB) begin
                    reg_out_ff <= wd_out;
                end
                if (wstrb[1]) begin
                    reg_clk384_ff <= wd_ff[`IF_CLK384];
                    if (wd_mode != `MODE_UNUSED && wd_mode <= `MODE_LAST) begin
                        reg_mode_ff <= wd_mode;
                    end
                    reg_pick_ff <= wd_ff[`IF_PICK_LSB +: 2];
                end
            end
        end
    end

    // ****************************************
    // Effective mode selection
    // ****************************************
    logic stat;
    logic [3:0] pin_mode;
    logic [3:0] eff_mode;
    logic [1:0] eff_pick;
    logic [5:0] eff_audio;
    logic [3:0] eff_src;

    assign stat = pin_ff.sel_static;
    assign pin_mode = 4'(pin_ff.app_select_pin2 * 6) +
                      4'(pin_ff.app_select_pin1 * 3) +
                      4'(lvl(pin_ff.app_select_pin0));
    assign eff_pick = stat ? {pin_ff.spdif_input_pick_hi,
                              pin_ff.spdif_input_pick_lo}
                           : reg_pick_ff;
    assign eff_audio = stat ? `RST_AUDIO : audio_ff;
    assign eff_src = stat ? `RST_SRC : pend_src_ff;

    // The unused pin code keeps the last valid mode instead of glitching
    assign eff_mode = !stat ? reg_mode_ff :
                      (pin_mode == `MODE_UNUSED) ? app_mode_ff
                                                 : pin_mode;

    always_ff @(posedge aclk) begin
        if (rst) begin
            app_mode_ff <= `RST_MODE;
            spdif_route_ff <= `RST_PICK;
            spdif_data_ff <= 1'b0;
            xtal_rate_ff <= 2'h0;
            in_fmt_ff <= `RST_FMT;
            out_fmt_ff <= `RST_FMT;
            bck_ratio_ff <= `BCK_RATIO_256;
            bck_ws_master_ff <= 1'b1;
            lock_ff <= 1'b0;
            dac_mute_ff <= 1'b0;
            mixer_en_ff <= 1'b0;
            mixer_pos_ff <= 1'b0;
        end else begin
            app_mode_ff <= eff_mode;
            spdif_route_ff <= eff_pick;
            spdif_data_ff <= pin_ff.spdif_rx[eff_pick];
            xtal_rate_ff <= lvl(pin_ff.crystal_rate_pick);
            if (stat) begin
                in_fmt_ff <= (pin_ff.sfor == 2'h0) ? FMT_I2S :
                             (pin_ff.sfor == 2'h1) ? FMT_LSB16 :
                             (pin_ff.sfor == 2'h2) ? FMT_LSB24
                                                    : FMT_MSB;
                out_fmt_ff <= (pin_ff.sfor == 2'h0) ? FMT_I2S
                                                     : FMT_MSB;
            end else begin
                in_fmt_ff <= reg_in_ff;
                out_fmt_ff <= reg_out_ff;
            end
            bck_ratio_ff <= (!stat && reg_clk384_ff) ? `BCK_RATIO_384
                                                     : `BCK_RATIO_256;
            bck_ws_master_ff <= eff_mode != 4'h1;
            lock_ff <= spdif_in(eff_mode) ? pin_ff.spdif_lock :
                       i2s_lock(eff_mode) ? pin_ff.pll_lock
                                          : 1'b0;
            dac_mute_ff <= pin_ff.mute || eff_audio[`AUD_MUTE_SW];
            mixer_en_ff <= eff_audio[`AUD_MIX_EN];
            mixer_pos_ff <= eff_audio[`AUD_MIX_POS];
        end
    end

    // ****************************************
    // Source mutes
    // ****************************************
    logic [6:0] pos1_ff, pos2_ff, posm_ff;

    always_ff @(posedge aclk) begin
        if (rst) begin
            ch1_src_ff <= 2'h0;
            ch2_src_ff <= 2'h0;
            source1_mute_flag_ff <= 1'b0;
            source2_mute_flag_ff <= 1'b0;
            pos1_ff <= 7'h00;
            pos2_ff <= 7'h00;
        end else begin
            pos1_ff <= ramp_next(pos1_ff, source1_mute_flag_ff, fs_tick);
            pos2_ff <= ramp_next(pos2_ff, source2_mute_flag_ff, fs_tick);
            // New source is applied only once the old one is fully silent
            if (source1_mute_flag_ff && pos1_ff == `RAMP_FULL) begin
                ch1_src_ff <= eff_src[`SRC_CH1_LSB +: 2];
                source1_mute_flag_ff <= 1'b0;
            end else if (eff_src[`SRC_CH1_LSB +: 2] != ch1_src_ff) begin
                source1_mute_flag_ff <= 1'b1;
            end
            if (source2_mute_flag_ff && pos2_ff == `RAMP_FULL) begin
                ch2_src_ff <= eff_src[`SRC_CH2_LSB +: 2];
                source2_mute_flag_ff <= 1'b0;
            end else if (eff_src[`SRC_CH2_LSB +: 2] != ch2_src_ff) begin
                source2_mute_flag_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // Master mute
    // ****************************************
    mstate_t mst_ff;
    logic prev_stat_ff;
    logic [3:0] prev_mode_ff;
    logic [1:0] prev_pick_ff;
    logic wait_lock_ff;
    logic mode_evt, pick_evt, aud_evt;

    // Mode changes take effect at once; only the output is held silent
    assign mode_evt = eff_mode != prev_mode_ff || stat != prev_stat_ff;
    assign pick_evt = eff_pick != prev_pick_ff && dac_on_pll(eff_mode);
    assign aud_evt = eff_audio[`AUD_NS_ORDER] != ns_order_ff ||
                     eff_audio[`AUD_DAC_POL] != dac_pol_ff ||
                     eff_audio[`AUD_XTAL_SRC] != xtal_src_ff;

    always_ff @(posedge aclk) begin
        if (rst) begin
            mst_ff <= M_IDLE;
            master_mute_flag_ff <= 1'b0;
            wait_lock_ff <= 1'b0;
            prev_stat_ff <= 1'b0;
            prev_mode_ff <= `RST_MODE;
            prev_pick_ff <= `RST_PICK;
            ns_order_ff <= 1'b0;
            dac_pol_ff <= 1'b0;
            xtal_src_ff <= 1'b0;
        end else begin
            prev_stat_ff <= stat;
            prev_mode_ff <= eff_mode;
            prev_pick_ff <= eff_pick;
            if (mode_evt || pick_evt || aud_evt) begin
                master_mute_flag_ff <= 1'b1;
                mst_ff <= M_MUTING;
            end
            if (mode_evt && dac_on_pll(eff_mode) || pick_evt) begin
                wait_lock_ff <= 1'b1;
            end
            case (mst_ff)
                M_IDLE: begin
                end
                M_MUTING: begin
                    if (posm_ff == `RAMP_FULL && !mode_evt && !pick_evt) begin
                        ns_order_ff <= eff_audio[`AUD_NS_ORDER];
                        dac_pol_ff <= eff_audio[`AUD_DAC_POL];
                        xtal_src_ff <= eff_audio[`AUD_XTAL_SRC];
                        if (wait_lock_ff) begin
                            mst_ff <= M_WAIT_LOCK;
                        end else begin
                            master_mute_flag_ff <= 1'b0;
                            mst_ff <= M_IDLE;
                        end
                    end
                end
                M_WAIT_LOCK: begin
                    // A fresh audio change keeps the flag up, set wins
                    if (pin_ff.pll_lock && !mode_evt && !pick_evt &&
                        !aud_evt) begin
                        master_mute_flag_ff <= 1'b0;
                        wait_lock_ff <= 1'b0;
                        mst_ff <= M_IDLE;
                    end
                end
                default: begin
                    mst_ff <= M_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Soft mute ramps
    // ****************************************
    always_ff @(posedge aclk) begin
        if (rst) begin
            posm_ff <= 7'h00;
            src1_coef_ff <= 5'h00;
            src2_coef_ff <= 5'h00;
            master_coef_ff <= 5'h00;
        end else begin
            posm_ff <= ramp_next(posm_ff, master_mute_flag_ff || dac_mute_ff,
                                 fs_tick);
            src1_coef_ff <= pos1_ff[6:2];
            src2_coef_ff <= pos2_ff[6:2];
            master_coef_ff <= posm_ff[6:2];
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (araddr)
            `OFS_SRC: rd_word = {28'h0000000, pend_src_ff};
            `OFS_AUDIO: rd_word = {26'h0, audio_ff};
            `OFS_IFACE: rd_word = {16'h0000, reg_pick_ff, 1'b0,
                                   reg_clk384_ff, reg_mode_ff, 1'b0,
                                   reg_out_ff, 1'b0, reg_in_ff};
            `OFS_STATUS: rd_word = {12'h000, xtal_rate_ff, spdif_route_ff,
                                    app_mode_ff, 4'h0, bck_ws_master_ff,
                                    stat, wait_lock_ff, dac_mute_ff, lock_ff,
                                    master_mute_flag_ff, source2_mute_flag_ff,
                                    source1_mute_flag_ff};
            `OFS_SOFT_RESET: rd_word = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else begin
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? 2'h0 : 2'h3;
            end
            if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

endmodule

// ===== common/mute_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MUTE_CTRL_MAP_SVH
`define MUTE_CTRL_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define OFS_SRC 9'h000
`define OFS_AUDIO 9'h004
`define OFS_IFACE 9'h008
`define OFS_STATUS 9'h00c
`define IDX_SOFT_RESET 7'h7f
`define OFS_SOFT_RESET {`IDX_SOFT_RESET, 2'b00}

// ****************************************
// Field positions
// ****************************************
`define SRC_CH1_LSB 0
`define SRC_CH2_LSB 2
`define AUD_NS_ORDER 0
`define AUD_DAC_POL 1
`define AUD_MIX_EN 2
`define AUD_MIX_POS 3
`define AUD_XTAL_SRC 4
`define AUD_MUTE_SW 5
`define IF_IN_LSB 0
`define IF_OUT_LSB 4
`define IF_MODE_LSB 8
`define IF_CLK384 12
`define IF_PICK_LSB 14

// ****************************************
// Reset values
// ****************************************
`define RST_SRC 4'h0
`define RST_AUDIO 6'h00
`define RST_FMT 3'h0
`define RST_MODE 4'h0
`define RST_PICK 2'h0

// ****************************************
// Ramp, clock ratios and mode codes
// ****************************************
`define RAMP_FULL 7'h7f
`define BCK_RATIO_256 7'h40
`define BCK_RATIO_384 7'h30
`define MODE_UNUSED 4'hb
`define MODE_LAST 4'he

`endif

// ===== common/mute_ctrl_pkg.sv
// Types shared by the mute and mode control block
package mute_ctrl_pkg;

    typedef enum logic [2:0] {
        FMT_I2S,
        FMT_LSB16,
        FMT_LSB18,
        FMT_LSB20,
        FMT_LSB24,
        FMT_MSB
    } fmt_t;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_MID = 2'h1,
        LVL_HIGH = 2'h2
    } level_t;

    typedef enum {
        M_IDLE,
        M_MUTING,
        M_WAIT_LOCK
    } mstate_t;

    typedef struct packed {
        logic sel_static;
        logic app_select_pin2;
        logic app_select_pin1;
        logic [1:0] app_select_pin0;
        logic spdif_input_pick_hi;
        logic spdif_input_pick_lo;
        logic [1:0] crystal_rate_pick;
        logic [1:0] sfor;
        logic mute;
        logic reset_req;
        logic [3:0] spdif_rx;
        logic pll_lock;
        logic spdif_lock;
    } pins_t;

endpackage

// ===== bench/mute_mode_ctrl_chk.sv
// Concurrent checks on the mute and mode control ports
`timescale 1ns/1ps
module mute_mode_ctrl_chk
    import mute_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pins_t pins,
    input wire logic fs_tick,
    input wire logic [1:0] ch1_src_ff,
    input wire logic [1:0] ch2_src_ff,
    input wire logic ns_order_ff,
    input wire logic mixer_en_ff,
    input wire logic bck_ws_master_ff,
    input wire logic dac_mute_ff,
    input wire logic source1_mute_flag_ff,
    input wire logic source2_mute_flag_ff,
    input wire logic master_mute_flag_ff,
    input wire logic [3:0] app_mode_ff,
    input wire logic [1:0] spdif_route_ff
);
    // ********
    // Helpers and properties
    // ********
    logic [7:0] ticks_ff;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Samples seen while source 1 is muted; saturates so it never wraps
    always_ff @(posedge aclk) begin
        if (!aresetn || !source1_mute_flag_ff) begin
            ticks_ff <= 8'h00;
        end else if (fs_tick && ticks_ff != 8'hff) begin
            ticks_ff <= ticks_ff + 8'h01;
        end
    end
    ramp_len_a: assert property (
        $fell(source1_mute_flag_ff) |-> ticks_ff >= 8'h7e)
        else $error("source mute released before full ramp");
    src1_gate_a: assert property (
        $changed(ch1_src_ff) |-> $past(source1_mute_flag_ff))
        else $error("channel 1 source moved while unmuted");
    src2_gate_a: assert property (
        $changed(ch2_src_ff) |-> $past(source2_mute_flag_ff))
        else $error("channel 2 source moved while unmuted");
    ns_gate_a: assert property (
        $changed(ns_order_ff) |-> $past(master_mute_flag_ff))
        else $error("shaper order moved while unmuted");
    mix_free_a: assert property (
        $changed(mixer_en_ff) && !$past(master_mute_flag_ff) &&
        pins.sel_static == $past(pins.sel_static, 5) |-> !master_mute_flag_ff)
        else $error("mixer change raised master mute");
    bck_dir_a: assert property (
        $stable(app_mode_ff)[*2] |-> bck_ws_master_ff == (app_mode_ff != 4'h1))
        else $error("bit clock direction disagrees with mode");
    ext_mute_a: assert property (
        pins.mute[*4] |-> dac_mute_ff)
        else $error("mute pin ignored");
    route_a: assert property (
        (pins.sel_static && $stable({pins.sel_static,
        pins.spdif_input_pick_hi, pins.spdif_input_pick_lo}))[*4]
        |-> spdif_route_ff == {pins.spdif_input_pick_hi,
        pins.spdif_input_pick_lo})
        else $error("spdif route disagrees with pick pins");
endmodule
bind mute_mode_ctrl mute_mode_ctrl_chk u_chk (.*);

// ===== bench/audio_peer.sv
// Behavioural audio peer: sample tick and lock sources
`timescale 1ns/1ps
module audio_peer (
    input wire logic aclk,
    input wire logic aresetn,
    output logic fs_tick,
    output logic pll_lock,
    output logic spdif_lock
);
    // ********
    // Sample rate and lock
    // ********
    logic [5:0] cnt_ff;
    logic [1:0] ph_ff = 2'h0;
    // Lock rises 32 cycles after reset and then holds, so later mode changes find it already high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff != 6'h3f) begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end
    // Sample clock keeps running through reset
    always_ff @(posedge aclk) begin
        ph_ff <= ph_ff + 2'h1;
        fs_tick <= (ph_ff == 2'h3);
    end
    assign pll_lock = cnt_ff[5];
    assign spdif_lock = cnt_ff[5];
endmodule

// ===== bench/mute_mode_ctrl_test.sv
// Self-checking bench for mute and mode control
`timescale 1ns/1ps
module mute_mode_ctrl_test
    import mute_ctrl_pkg::*;
;
    // ********
    // Signals and instances
    // ********
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fs_tick, pll_lock, spdif_lock;
    logic [8:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, app_mode_ff;
    logic [1:0] bresp, rresp, ch1_src_ff, ch2_src_ff;
    logic [1:0] spdif_route_ff, xtal_rate_ff;
    logic [2:0] in_fmt_ff, out_fmt_ff;
    logic [6:0] bck_ratio_ff;
    logic ns_order_ff, mixer_en_ff, bck_ws_master_ff, lock_ff, dac_mute_ff;
    logic source1_mute_flag_ff, source2_mute_flag_ff, master_mute_flag_ff;
    pins_t pins, pin_v;
    int mismatches = 0, n_compared = 0;
    audio_peer u_peer (.aclk, .aresetn, .fs_tick, .pll_lock, .spdif_lock);
    mute_mode_ctrl u_dut (.*, .dac_pol_ff(), .mixer_pos_ff(), .xtal_src_ff(),
        .src1_coef_ff(), .src2_coef_ff(), .master_coef_ff(), .spdif_data_ff());
    always_comb begin
        pins = pin_v;
        pins.pll_lock = pll_lock;
        pins.spdif_lock = spdif_lock;
    end
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic quiet();
        for (int i = 0; i < 1500; i++) begin
            @(posedge aclk);
            if ({source1_mute_flag_ff, source2_mute_flag_ff,
                master_mute_flag_ff} === 3'h0) break;
        end
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
        end while (!bvalid);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        settle(40);
        chk(bck_ratio_ff, 7'h40);
        chk({in_fmt_ff, out_fmt_ff, bck_ws_master_ff}, 7'h01);
        chk(lock_ff, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_src(input logic [31:0] d, input logic [1:0] f);
        wr(9'h000, d);
        settle(1);
        chk({source2_mute_flag_ff, source1_mute_flag_ff,
            master_mute_flag_ff}, {f, 1'b0});
        quiet();
        chk({ch2_src_ff, ch1_src_ff}, d[3:0]);
        $display("test source done");
    endtask
    task automatic t_fmt();
        logic [31:0] d;
        logic [1:0] r;
        wr(9'h008, 32'h0000_1032);
        settle(3);
        chk({in_fmt_ff, out_fmt_ff}, {3'h2, 3'h3});
        chk(bck_ratio_ff, 7'h30);
        @(posedge aclk);
        araddr <= 9'h010;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end while (!rvalid);
        chk({r, d[3:0]}, 6'h30);
        $display("test format done");
    endtask
    task automatic t_audio();
        wr(9'h004, 32'h0000_000c);
        settle(3);
        chk({master_mute_flag_ff, mixer_en_ff}, 2'h1);
        wr(9'h004, 32'h0000_000d);
        settle(1);
        chk({master_mute_flag_ff, ns_order_ff}, 2'h2);
        quiet();
        chk(ns_order_ff, 1'b1);
        @(posedge aclk);
        pin_v.mute <= 1'b1;
        settle(6);
        chk(dac_mute_ff, 1'b1);
        @(posedge aclk);
        pin_v.mute <= 1'b0;
        quiet();
        $display("test audio done");
    endtask
    task automatic t_static();
        @(posedge aclk);
        pin_v.sel_static <= 1'b1;
        pin_v.sfor <= 2'h1;
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            {pin_v.spdif_input_pick_hi, pin_v.spdif_input_pick_lo} <= i[1:0];
            pin_v.crystal_rate_pick <= i[1:0];
            settle(6);
            chk(spdif_route_ff, i[1:0]);
            chk(xtal_rate_ff, (i == 3) ? 2'h2 : i[1:0]);
        end
        chk({in_fmt_ff, out_fmt_ff}, {3'h1, 3'h5});
        chk(bck_ratio_ff, 7'h40);
        @(posedge aclk);
        pin_v.app_select_pin0 <= 2'h1;
        settle(6);
        chk({app_mode_ff, bck_ws_master_ff}, 5'h02);
        quiet();
        chk(lock_ff, 1'b1);
        $display("test static done");
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        pin_v = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_src(32'h0000_0001, 2'h1);
        t_src(32'h0000_0009, 2'h2);
        t_fmt();
        t_audio();
        t_static();
        test_done();
    end
endmodule
